// ---- rtl/lfd_frame_drive.sv ----
// lcd frame timing, drive method and booster selection behind an axi4-lite slave
// Functional notes
// RULE_01 - four drive methods picked by select field
// RULE_02 - 00 quarter, 01 third, 10 half, 11 static
// RULE_03 - fast clock bases: 2^17, 2^16, 2^15, 2^13
// RULE_04 - slow clock bases: 2^9 and 2^8
// RULE_05 - software avoids base 10/11 on slow clock
// RULE_06 - frame rate scaled by duty: 1, 4/3, 2
// RULE_07 - booster_enable picks booster or external divider
// RULE_08 - boost_freq_select sets booster pump clock
// RULE_09 - software avoids pump setting 11 on slow clock
// RULE_10 - booster on requires one third bias
// RULE_11 - phase divider restarts when selection rewritten
//
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module lfd_frame_drive
  import lfd_pkg::*;
#(
  parameter int CNT_WIDTH = 17,
  parameter logic [4:0] HF_FRAME_EXP_0 = LFD_HF_FRAME_EXP_0,
  parameter logic [4:0] HF_FRAME_EXP_1 = LFD_HF_FRAME_EXP_1,
  parameter logic [4:0] HF_FRAME_EXP_2 = LFD_HF_FRAME_EXP_2,
  parameter logic [4:0] HF_FRAME_EXP_3 = LFD_HF_FRAME_EXP_3,
  parameter logic [4:0] HF_BOOST_EXP_0 = LFD_HF_BOOST_EXP_0
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic low_freq_clock,
  output logic [3:0] com_select,
  output logic frame_polarity,
  output logic frame_start,
  output logic display_enable,
  output logic booster_enable,
  output logic bias_half,
  output logic boost_pump_clk
);

  // bus state
  logic aw_have_reg, aw_have_next;
  logic [7:0] aw_addr_reg, aw_addr_next;
  logic w_have_reg, w_have_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [7:0] lcd_control_reg, lcd_control_next;
  logic [1:0] clksel_reg, clksel_next;
  logic wr_fire;
  logic restart;
  logic [31:0] status_word;

  // timing state
  lfd_phase_e phase_reg, phase_next;
  lfd_phase_e last_phase;
  logic [3:0] com_reg, com_next;
  logic pol_reg, pol_next;
  logic fstart_reg, fstart_next;
  logic pump_reg, pump_next;
  logic lf_sync1_reg, lf_sync2_reg, lf_sync3_reg;
  logic lf_edge;
  logic frame_use_lf, boost_use_lf;
  logic [4:0] frame_exp, boost_exp;
  logic phase_tick, boost_tick;

  // field views
  logic [1:0] frame_base_select, vf;
  lfd_duty_e duty;
  logic div_src_sel, sys_clk_sel;
  assign frame_base_select = lcd_control_reg[LFD_FRAME_BASE_LSB +: 2];
  assign vf = lcd_control_reg[LFD_VF_LSB +: 2];
  assign duty = lfd_duty_e'(lcd_control_reg[LFD_DUTY_LSB +: 2]);
  assign div_src_sel = clksel_reg[LFD_DIVSRC_BIT];
  assign sys_clk_sel = clksel_reg[LFD_SYSCLK_BIT];

  // write fires once address and data are both held and no response pends
  assign wr_fire = aw_have_reg & w_have_reg & ~bvalid_reg;
  // any rewrite of the selection restarts the phase sequence
  assign restart = wr_fire & w_strb_reg[0] & ((aw_addr_reg == LFD_CTRL_OFFSET) |
                   (aw_addr_reg == LFD_CLKSEL_OFFSET)); // see RULE_11

  assign status_word = {24'h000000, 1'b0, boost_use_lf, frame_use_lf, pump_reg, pol_reg, phase_reg[2:0]};

  // axi4-lite slave, one write and one read in flight
  always_comb
  begin
    aw_have_next = aw_have_reg;
    aw_addr_next = aw_addr_reg;
    w_have_next = w_have_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    lcd_control_next = lcd_control_reg;
    clksel_next = clksel_reg;
    if (s_axi_awvalid && !aw_have_reg)
    begin
      aw_have_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_have_reg)
    begin
      w_have_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (bvalid_reg && s_axi_bready)
    begin
      bvalid_next = 1'b0;
    end
    if (wr_fire)
    begin
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = LFD_RESP_OKAY;
      case (aw_addr_reg)
        LFD_CTRL_OFFSET:
        begin
          if (w_strb_reg[0])
          begin
            lcd_control_next = w_data_reg[7:0]; // see RULE_01
          end
        end
        LFD_CLKSEL_OFFSET:
        begin
          if (w_strb_reg[0])
          begin
            clksel_next = w_data_reg[1:0];
          end
        end
        LFD_STATUS_OFFSET: bresp_next = LFD_RESP_OKAY; // read-only, write ignored
        default: bresp_next = LFD_RESP_SLVERR;
      endcase
    end
    if (rvalid_reg && s_axi_rready)
    begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_reg)
    begin
      rvalid_next = 1'b1;
      rresp_next = LFD_RESP_OKAY;
      case (s_axi_araddr)
        LFD_CTRL_OFFSET: rdata_next = {24'h000000, lcd_control_reg};
        LFD_CLKSEL_OFFSET: rdata_next = {30'h00000000, clksel_reg};
        LFD_STATUS_OFFSET: rdata_next = status_word;
        default:
        begin
          rdata_next = 32'h00000000;
          rresp_next = LFD_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_have_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= LFD_RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= LFD_RESP_OKAY;
      lcd_control_reg <= LFD_CTRL_RESET;
      clksel_reg <= LFD_CLKSEL_RESET;
    end
    else
    begin
      aw_have_reg <= aw_have_next;
      aw_addr_reg <= aw_addr_next;
      w_have_reg <= w_have_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      lcd_control_reg <= lcd_control_next;
      clksel_reg <= clksel_next;
    end
  end

  assign s_axi_awready = ~aw_have_reg;
  assign s_axi_wready = ~w_have_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // low_freq_clock is a pin: two flops, then an edge on the settled copy
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lf_sync1_reg <= 1'b0;
      lf_sync2_reg <= 1'b0;
      lf_sync3_reg <= 1'b0;
    end
    else
    begin
      lf_sync1_reg <= low_freq_clock;
      lf_sync2_reg <= lf_sync1_reg;
      lf_sync3_reg <= lf_sync2_reg;
    end
  end
  assign lf_edge = lf_sync2_reg & ~lf_sync3_reg;

  // source and divide selection; pump 11 always, and bases 10/11 unless sys_clk_sel is set, fall back from the slow clock to the fast one
  always_comb
  begin
    frame_use_lf = sys_clk_sel | (div_src_sel & ~frame_base_select[1]); // see RULE_04, see RULE_05
    boost_use_lf = (sys_clk_sel | div_src_sel) & (vf != 2'b11); // see RULE_09
    case (frame_base_select)
      2'b00: frame_exp = frame_use_lf ? LFD_LF_FRAME_EXP_0 : HF_FRAME_EXP_0; // see RULE_03
      2'b01: frame_exp = frame_use_lf ? LFD_LF_FRAME_EXP_1 : HF_FRAME_EXP_1;
      2'b10: frame_exp = HF_FRAME_EXP_2;
      default: frame_exp = HF_FRAME_EXP_3;
    endcase
    case (vf)
      2'b00: boost_exp = boost_use_lf ? LFD_LF_BOOST_EXP_0 : HF_BOOST_EXP_0; // see RULE_08
      2'b01: boost_exp = boost_use_lf ? LFD_LF_BOOST_EXP_1 : LFD_HF_BOOST_EXP_1;
      2'b10: boost_exp = boost_use_lf ? LFD_LF_BOOST_EXP_2 : LFD_HF_BOOST_EXP_2;
      default: boost_exp = LFD_HF_BOOST_EXP_3;
    endcase
  end

  // common phase period is a quarter of the base period
  lfd_pow2_div #(.WIDTH(CNT_WIDTH)) u_phase_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .restart(restart),
    .tick_in(frame_use_lf ? lf_edge : 1'b1),
    .shift(frame_exp - LFD_PHASE_EXP_DROP),
    .tick_out(phase_tick)
  );

  // pump toggles every half pump period
  lfd_pow2_div #(.WIDTH(CNT_WIDTH)) u_boost_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .restart(1'b0),
    .tick_in(boost_use_lf ? lf_edge : 1'b1),
    .shift(boost_exp - LFD_HALF_EXP_DROP),
    .tick_out(boost_tick)
  );

  // frame length in phases: 4, 3, 2 and 4 for static, giving base x 1, 4/3, 2, 1
  always_comb
  begin
    case (duty)
      LFD_DUTY_THIRD: last_phase = LFD_COM2; // see RULE_06
      LFD_DUTY_HALF: last_phase = LFD_COM1;
      default: last_phase = LFD_COM3;
    endcase
    phase_next = phase_reg;
    pol_next = pol_reg;
    fstart_next = 1'b0;
    pump_next = pump_reg ^ boost_tick;
    if (restart)
    begin
      phase_next = LFD_COM0; // see RULE_11
      pol_next = 1'b0;
    end
    else if (phase_tick)
    begin
      if (phase_reg == last_phase)
      begin
        phase_next = LFD_COM0;
        pol_next = ~pol_reg; // alternate polarity to keep the panel free of dc
        fstart_next = 1'b1;
      end
      else
      begin
        case (phase_reg)
          LFD_COM0: phase_next = LFD_COM1;
          LFD_COM1: phase_next = LFD_COM2;
          LFD_COM2: phase_next = LFD_COM3;
          default: phase_next = LFD_COM0;
        endcase
      end
    end
    // static drive keeps one common asserted for the whole frame
    com_next = (duty == LFD_DUTY_STATIC) ? LFD_COM0 : phase_next; // see RULE_02
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      phase_reg <= LFD_COM0;
      com_reg <= 4'h1;
      pol_reg <= 1'b0;
      fstart_reg <= 1'b0;
      pump_reg <= 1'b0;
    end
    else
    begin
      phase_reg <= phase_next;
      com_reg <= com_next;
      pol_reg <= pol_next;
      fstart_reg <= fstart_next;
      pump_reg <= pump_next;
    end
  end

  assign com_select = com_reg;
  assign frame_polarity = pol_reg;
  assign frame_start = fstart_reg;
  assign display_enable = lcd_control_reg[LFD_DSP_EN_BIT];
  assign booster_enable = lcd_control_reg[LFD_BOOST_EN_BIT]; // see RULE_07
  // software keeps this low while the booster runs
  assign bias_half = (duty == LFD_DUTY_HALF); // see RULE_10
  assign boost_pump_clk = pump_reg;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_write_resp: assert property (wr_fire |=> s_axi_bvalid && $stable(aw_addr_reg)) // see RULE_01
    else $error("write response missing");
  a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) // see RULE_01
    else $error("read response missing");
  a_ctrl_store: assert property (wr_fire && w_strb_reg[0] && aw_addr_reg == LFD_CTRL_OFFSET // see RULE_01
    |=> lcd_control_reg == $past(w_data_reg[7:0]))
    else $error("control register not stored");
  a_phase_restart: assert property (restart |=> phase_reg == LFD_COM0 && !frame_polarity) // see RULE_11
    else $error("phase did not restart");
  a_frame_wrap: assert property (!restart && phase_tick && phase_reg == last_phase // see RULE_06
    |=> frame_start && phase_reg == LFD_COM0 && frame_polarity != $past(frame_polarity))
    else $error("frame did not wrap");
  a_com_static: assert property (duty == LFD_DUTY_STATIC && $stable(duty) |=> com_select == 4'h1) // see RULE_02
    else $error("static drive com wrong");
  a_com_onehot: assert property ($onehot(com_select)) // see RULE_01
    else $error("com select not one-hot");
  a_frame_source: assert property (sys_clk_sel && !frame_base_select[1] |-> frame_use_lf // see RULE_04
    && frame_exp == (frame_base_select[0] ? LFD_LF_FRAME_EXP_1 : LFD_LF_FRAME_EXP_0))
    else $error("slow frame source wrong");
  a_fast_base: assert property (!sys_clk_sel && !div_src_sel && frame_base_select == 2'b00 // see RULE_03
    |-> frame_exp == HF_FRAME_EXP_0)
    else $error("fast frame base wrong");
  a_pump_toggle: assert property (boost_tick |=> boost_pump_clk != $past(boost_pump_clk)) // see RULE_08
    else $error("pump did not toggle");

endmodule : lfd_frame_drive

`default_nettype wire

// ---- inc/lfd_pkg.sv ----
// shared constants and types for the lcd frame and drive selection block
package lfd_pkg;

  // register byte offsets
  localparam logic [7:0] LFD_CTRL_OFFSET = 8'h28;
  localparam logic [7:0] LFD_CLKSEL_OFFSET = 8'h2c;
  localparam logic [7:0] LFD_STATUS_OFFSET = 8'h30;

  // values after reset
  localparam logic [7:0] LFD_CTRL_RESET = 8'h00;
  localparam logic [1:0] LFD_CLKSEL_RESET = 2'h0;

  // lcd_control_reg field positions
  localparam int LFD_DSP_EN_BIT = 7;
  localparam int LFD_BOOST_EN_BIT = 6;
  localparam int LFD_VF_LSB = 4;
  localparam int LFD_DUTY_LSB = 2;
  localparam int LFD_FRAME_BASE_LSB = 0;

  // clock select register field positions
  localparam int LFD_DIVSRC_BIT = 0;
  localparam int LFD_SYSCLK_BIT = 1;

  // axi response codes
  localparam logic [1:0] LFD_RESP_OKAY = 2'h0;
  localparam logic [1:0] LFD_RESP_SLVERR = 2'h2;

  // frame base exponents: high_freq_clock / 2^n and low_freq_clock / 2^n
  localparam logic [4:0] LFD_HF_FRAME_EXP_0 = 5'h11;
  localparam logic [4:0] LFD_HF_FRAME_EXP_1 = 5'h10;
  localparam logic [4:0] LFD_HF_FRAME_EXP_2 = 5'h0f;
  localparam logic [4:0] LFD_HF_FRAME_EXP_3 = 5'h0d;
  localparam logic [4:0] LFD_LF_FRAME_EXP_0 = 5'h09;
  localparam logic [4:0] LFD_LF_FRAME_EXP_1 = 5'h08;

  // booster pump exponents
  localparam logic [4:0] LFD_HF_BOOST_EXP_0 = 5'h0d;
  localparam logic [4:0] LFD_HF_BOOST_EXP_1 = 5'h0b;
  localparam logic [4:0] LFD_HF_BOOST_EXP_2 = 5'h0a;
  localparam logic [4:0] LFD_HF_BOOST_EXP_3 = 5'h09;
  localparam logic [4:0] LFD_LF_BOOST_EXP_0 = 5'h05;
  localparam logic [4:0] LFD_LF_BOOST_EXP_1 = 5'h03;
  localparam logic [4:0] LFD_LF_BOOST_EXP_2 = 5'h02;

  // a common phase lasts a quarter of the base period
  localparam logic [4:0] LFD_PHASE_EXP_DROP = 5'h02;
  // a pump half period is half of the pump period
  localparam logic [4:0] LFD_HALF_EXP_DROP = 5'h01;

  // drive method encodings
  typedef enum logic [1:0] {
    LFD_DUTY_QUARTER = 2'b00,
    LFD_DUTY_THIRD = 2'b01,
    LFD_DUTY_HALF = 2'b10,
    LFD_DUTY_STATIC = 2'b11
  } lfd_duty_e;

  // common phase states, one-hot
  typedef enum logic [3:0] {
    LFD_COM0 = 4'b0001,
    LFD_COM1 = 4'b0010,
    LFD_COM2 = 4'b0100,
    LFD_COM3 = 4'b1000
  } lfd_phase_e;

endpackage : lfd_pkg

// ---- rtl/lfd_pow2_div.sv ----
// power-of-two tick divider with clean restart
`timescale 1ns/1ps
`default_nettype none

module lfd_pow2_div
  import lfd_pkg::*;
#(
  parameter int WIDTH = 17
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic restart,
  input wire logic tick_in,
  input wire logic [4:0] shift,
  output logic tick_out
);

  logic [WIDTH-1:0] cnt_reg;
  logic [WIDTH-1:0] cnt_next;
  logic [WIDTH-1:0] mask;
  logic tick_reg;
  logic tick_next;

  // one output tick per 2^shift input ticks; restart wins over counting
  always_comb
  begin
    mask = WIDTH'((32'h1 << shift) - 32'h1);
    cnt_next = cnt_reg;
    tick_next = 1'b0;
    if (restart)
    begin
      cnt_next = '0;
    end
    else if (tick_in)
    begin
      if ((cnt_reg & mask) == mask)
      begin
        cnt_next = '0;
        tick_next = 1'b1;
      end
      else
      begin
        cnt_next = cnt_reg + WIDTH'(1);
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_reg <= '0;
      tick_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick_out = tick_reg;

endmodule : lfd_pow2_div

`default_nettype wire

// ---- dv/lfd_panel_model.sv ----
// lcd panel model: watches the common lines and frame markers
`timescale 1ns/1ps
`default_nettype none

module lfd_panel_model
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] com_select,
  input wire logic frame_polarity,
  input wire logic frame_start,
  output logic [31:0] frame_len,
  output logic [3:0] com_seen,
  output logic pol_flip,
  output logic [31:0] bad_com
);
  logic [31:0] cnt;
  logic [3:0] acc;
  logic last_pol;

  // the panel only tolerates one active common; frames logged start to start
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt <= 32'h0;
      acc <= 4'h0;
      last_pol <= 1'b0;
      frame_len <= 32'h0;
      com_seen <= 4'h0;
      pol_flip <= 1'b0;
      bad_com <= 32'h0;
    end
    else
    begin
      cnt <= cnt + 32'h1;
      acc <= acc | com_select;
      if (!$onehot(com_select))
        bad_com <= bad_com + 32'h1;
      if (frame_start)
      begin
        frame_len <= cnt;
        cnt <= 32'h1;
        com_seen <= acc;
        acc <= com_select;
        pol_flip <= frame_polarity != last_pol; // ac drive needs a flip each frame
        last_pol <= frame_polarity;
      end
    end
  end
endmodule : lfd_panel_model
`default_nettype wire

// ---- dv/lcd_frame_and_drive_select_test.sv ----
// testbench for the lcd frame and drive selection block
`timescale 1ns/1ps
`default_nettype none

module lcd_frame_and_drive_select_test import lfd_pkg::*;;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, lfc;
  logic [7:0] awaddr, araddr, ctrl;
  logic [31:0] wdata, rdata, rd, frame_len, bad_com;
  logic [3:0] wstrb, com_select, com_seen;
  logic [1:0] bresp, rresp, resp;
  logic awready, wready, bvalid, arready, rvalid, frame_polarity, frame_start;
  logic display_enable, booster_enable, bias_half, boost_pump_clk, pol_flip, pump_q, wr_pol;
  logic [3:0] wr_com;
  int failures, comparisons, pump_cnt, pump_per;
  // shortened fast-clock frame exponents; slow clock is 10 aclk per period
  int fexp[4] = '{4, 3, 5, 6};
  int ph[4] = '{4, 3, 2, 4};
  logic [3:0] cm[4] = '{4'hf, 4'h7, 4'h3, 4'h1};
  logic [1:0] pv[4] = '{2'h0, 2'h3, 2'h2, 2'h1};
  int pp[4] = '{8, 512, 1024, 2048};

  lfd_frame_drive #(.HF_FRAME_EXP_0(5'h04), .HF_FRAME_EXP_1(5'h03), .HF_FRAME_EXP_2(5'h05),
    .HF_FRAME_EXP_3(5'h06), .HF_BOOST_EXP_0(5'h03)) i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .low_freq_clock(lfc), .com_select(com_select),
    .frame_polarity(frame_polarity), .frame_start(frame_start), .display_enable(display_enable),
    .booster_enable(booster_enable), .bias_half(bias_half), .boost_pump_clk(boost_pump_clk));

  lfd_panel_model i_panel (.aclk(aclk), .aresetn(aresetn), .com_select(com_select),
    .frame_polarity(frame_polarity), .frame_start(frame_start), .frame_len(frame_len),
    .com_seen(com_seen), .pol_flip(pol_flip), .bad_com(bad_com));

  // clock and a free-running slow clock of unrelated phase
  always #2.5 aclk = ~aclk;
  initial
  begin
    lfc = 1'b0;
    #1.3;
    forever #25 lfc = ~lfc;
  end

  // pump period in aclk cycles, rise to rise
  always @(posedge aclk)
  begin
    pump_q <= boost_pump_clk;
    pump_cnt <= (boost_pump_clk && !pump_q) ? 1 : pump_cnt + 1;
    if (boost_pump_clk && !pump_q)
      pump_per <= pump_cnt;
  end

  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task conclude;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  // axi write; also latches the timing outputs in the cycle bvalid is seen
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= st;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid && bready)
      begin
        resp = bresp;
        wr_com = com_select;
        wr_pol = frame_polarity;
        bready <= 1'b0;
        break;
      end
    end
  endtask : wr

  task rdr(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid && rready)
      begin
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask : rdr

  // write control and check restart, readback and decoded outputs
  task set_ctrl(input logic [7:0] c);
    wr(LFD_CTRL_OFFSET, {24'h0, c}, 4'hf);
    chk("ctrl bresp", resp, LFD_RESP_OKAY);
    chk("com after write", wr_com, 4'h1);
    chk("polarity after write", wr_pol, 1'b0);
    rdr(LFD_CTRL_OFFSET);
    chk("ctrl readback", rd, {24'h0, c});
    chk("booster_enable", booster_enable, c[6]);
    chk("bias_half", bias_half, c[3:2] == 2'b10);
  endtask : set_ctrl

  // skip the restart frame and one more, then judge a whole frame
  task frame_chk(input int len, input logic [3:0] com);
    // look just after each edge, where the registered pulse has settled
    repeat (3)
    begin
      do
      begin
        @(posedge aclk);
        #1;
      end
      while (frame_start !== 1'b1);
    end
    // the panel logs the frame at the edge that samples the pulse
    @(posedge aclk);
    #1;
    chk("frame length", frame_len, len);
    chk("commons visited", com_seen, com);
    chk("polarity flip", pol_flip, 1'b1);
  endtask : frame_chk

  task pump_chk(input logic [7:0] c, input int per);
    set_ctrl(c);
    repeat (3 * per + 2100) @(posedge aclk);
    chk("pump period", pump_per, per);
  endtask : pump_chk

  initial
  begin
    #(90000 * 5);
    failures++;
    conclude();
  end

  initial
  begin
    aclk = 1'b0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, wstrb} = '0;
    failures = 0;
    comparisons = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    chk("com at reset", com_select, 4'h1);
    chk("booster at reset", booster_enable, 1'b0);
    rdr(LFD_CTRL_OFFSET);
    chk("ctrl reset", rd, {24'h0, LFD_CTRL_RESET});
    rdr(LFD_CLKSEL_OFFSET);
    chk("clksel reset", rd, {30'h0, LFD_CLKSEL_RESET});
    // unmapped place, read-only status and a write with no byte enabled
    wr(8'h3c, 32'h0000_00ff, 4'hf);
    chk("unmapped bresp", resp, LFD_RESP_SLVERR);
    rdr(8'h3c);
    chk("unmapped rresp", resp, LFD_RESP_SLVERR);
    chk("unmapped rdata", rd, 32'h0);
    wr(LFD_STATUS_OFFSET, 32'h0000_007f, 4'hf);
    chk("status bresp", resp, LFD_RESP_OKAY);
    wr(LFD_CTRL_OFFSET, 32'h0000_00ff, 4'h0);
    rdr(LFD_CTRL_OFFSET);
    chk("ctrl unstrobed", rd, 32'h0);
    // every duty against every fast base; booster only with third bias
    for (int d = 0; d < 4; d++)
      for (int s = 0; s < 4; s++)
      begin
        ctrl = {1'b1, d < 2, 2'b00, 2'(d), 2'(s)};
        set_ctrl(ctrl);
        chk("display_enable", display_enable, 1'b1);
        frame_chk(ph[d] * (1 << (fexp[s] - 2)), cm[d]);
      end
    for (int i = 0; i < 4; i++)
      pump_chk({2'b01, pv[i], 4'h0}, pp[i]);
    // divider source on the slow clock
    wr(LFD_CLKSEL_OFFSET, 32'h1, 4'hf);
    pump_chk(8'h40, 320);
    pump_chk(8'h70, 512);
    set_ctrl(8'h00);
    frame_chk(4 * 128 * 10, 4'hf);
    rdr(LFD_STATUS_OFFSET);
    chk("frame source slow", rd[5], 1'b1);
    set_ctrl(8'h05);
    frame_chk(3 * 64 * 10, 4'h7);
    // processor on the slow clock: bases 10/11 and pump 11 stay unused
    wr(LFD_CLKSEL_OFFSET, 32'h2, 4'hf);
    set_ctrl(8'h08);
    frame_chk(2 * 128 * 10, 4'h3);
    chk("one-hot commons", bad_com, 32'h0);
    conclude();
  end
endmodule : lcd_frame_and_drive_select_test
`default_nettype wire
